// [shared/tmafl_pkg.sv]
`default_nettype none
package tmafl_pkg;

    // ----------------------------------------------------------------
    // Register offsets on the plain register port
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_MAX_SCAN  = 8'h09;
    localparam logic [7:0] REG_START_HI  = 8'h0c;
    localparam logic [7:0] REG_START_LO  = 8'h0d;
    localparam logic [7:0] REG_SCR_CTL   = 8'h18;
    localparam logic [7:0] REG_ADJ_HI    = 8'h1a;
    localparam logic [7:0] REG_ADJ_LO    = 8'h1b;
    localparam logic [7:0] REG_CTL1      = 8'h20;
    localparam logic [7:0] REG_MODE_CTL  = 8'h30;
    localparam logic [7:0] REG_LAYOUT    = 8'h31;
    localparam logic [7:0] REG_STATUS    = 8'h32;

    // ----------------------------------------------------------------
    // Field positions and values after reset
    // ----------------------------------------------------------------
    localparam int MODE_RUN_BIT     = 0;
    localparam int MODE_BLINK_BIT   = 5;
    localparam int SCR_MONO_BIT     = 0;
    localparam int SCR_FONT2_BIT    = 3;
    localparam int CTL1_SPECIAL_BIT = 2;

    localparam logic [7:0] MODE_CTL_RST = 8'h01;
    localparam logic [4:0] MAX_SCAN_RST = 5'h07;

    // ----------------------------------------------------------------
    // Text layouts and their geometry
    // ----------------------------------------------------------------
    localparam logic [1:0]  LAYOUT_80X25 = 2'h0;
    localparam logic [1:0]  LAYOUT_40X25 = 2'h1;
    localparam logic [1:0]  LAYOUT_60X40 = 2'h2;
    localparam logic [13:0] STRIDE_80    = 14'h00a0;
    localparam logic [13:0] STRIDE_40    = 14'h0050;
    localparam logic [13:0] STRIDE_60    = 14'h0078;
    localparam logic [6:0]  LAST_COL_80  = 7'h4f;
    localparam logic [6:0]  LAST_COL_40  = 7'h27;
    localparam logic [6:0]  LAST_COL_60  = 7'h3b;
    localparam logic [5:0]  LAST_ROW_25  = 6'h18;
    localparam logic [5:0]  LAST_ROW_40  = 6'h27;
    localparam logic [13:0] CELL_STEP    = 14'h0002;
    localparam logic        DISPLAY_TOP  = 1'b0;

    // ----------------------------------------------------------------
    // Font areas: top three address bits, attribute codes, blink rate
    // ----------------------------------------------------------------
    localparam logic [2:0] FONT_TOP_MONO    = 3'h6;
    localparam logic [2:0] FONT_TOP_SPECIAL = 3'h5;
    localparam logic [2:0] FONT_TOP_NARROW  = 3'h7;
    localparam logic [2:0] LINE_GFX_TOP     = 3'h6;
    localparam logic [2:0] FIELD_NONE       = 3'h0;
    localparam logic [2:0] FIELD_UNDERLINE  = 3'h1;
    localparam logic [2:0] FIELD_FULL       = 3'h7;
    localparam logic [3:0] BLINK_LAST_FRAME = 4'hf;

    typedef enum logic [1:0] {ST_CHAR, ST_ATTR, ST_FONT} tmafl_fsm_t;

    // ----------------------------------------------------------------
    // Shared decoders
    // ----------------------------------------------------------------
    function automatic logic [13:0] tmafl_stride(input logic [1:0] layout);
        case (layout)
            LAYOUT_40X25: tmafl_stride = STRIDE_40;
            LAYOUT_60X40: tmafl_stride = STRIDE_60;
            default:      tmafl_stride = STRIDE_80;
        endcase
    endfunction

    function automatic logic [6:0] tmafl_last_col(input logic [1:0] layout);
        case (layout)
            LAYOUT_40X25: tmafl_last_col = LAST_COL_40;
            LAYOUT_60X40: tmafl_last_col = LAST_COL_60;
            default:      tmafl_last_col = LAST_COL_80;
        endcase
    endfunction

    function automatic logic [5:0] tmafl_last_row(input logic [1:0] layout);
        tmafl_last_row = (layout == LAYOUT_60X40) ? LAST_ROW_40 : LAST_ROW_25;
    endfunction

    // Character code on bits 10..3, glyph row on 2..0, bit 11 splits area
    function automatic logic [14:0] tmafl_font_addr(input logic [7:0] code,
                                                    input logic [3:0] row,
                                                    input logic       mono,
                                                    input logic       special,
                                                    input logic       font2);
        logic [2:0] top;
        logic       b11;
        top = mono ? FONT_TOP_MONO : (special ? FONT_TOP_SPECIAL : FONT_TOP_NARROW);
        b11 = (mono || special) ? row[3] : ~font2;
        tmafl_font_addr = {top, b11, code, row[2:0]};
    endfunction

endpackage
`default_nettype wire

// [core/tmafl_attr_decode.sv]
`timescale 1ns/100ps
`default_nettype none
module tmafl_attr_decode (
    input  wire logic [7:0] attr_in,
    input  wire logic [7:0] font_byte_in,
    input  wire logic [7:0] char_code_in,
    input  wire logic       mono_in,
    input  wire logic       blink_en_in,
    input  wire logic       blink_phase_in,
    input  wire logic       underline_row_in,
    output logic      [7:0] pixels_out,
    output logic            col9_out,
    output logic            high_intensity_out
);
    import tmafl_pkg::*;

    logic [2:0] background_field;
    logic [2:0] foreground_field;
    logic       intensity_bit;
    logic       hidden;
    logic       reverse;

    // ----------------------------------------------------------------
    // Attribute fields
    // ----------------------------------------------------------------
    assign background_field = attr_in[6:4];
    assign foreground_field = attr_in[2:0];
    assign intensity_bit    = attr_in[3];
    assign high_intensity_out = intensity_bit;
    assign reverse = mono_in && background_field == FIELD_FULL && foreground_field == FIELD_NONE;

    // Blink hides the glyph only while the mode register allows blinking
    assign hidden = attr_in[7] && blink_en_in && blink_phase_in;

    // Monochrome codes are decoded jointly; colour mode shows the glyph
    always_comb begin
        pixels_out = font_byte_in;
        if (mono_in) begin
            if (background_field == FIELD_NONE && foreground_field == FIELD_NONE) begin
                pixels_out = 8'h00;
            end else if (reverse) begin
                pixels_out = ~font_byte_in;
            end else if (background_field == FIELD_NONE && foreground_field == FIELD_UNDERLINE
                         && underline_row_in) begin
                pixels_out = 8'hff;
            end
        end
        if (hidden) begin
            pixels_out = reverse ? 8'hff : 8'h00;
        end
    end

    // Ninth column: line-drawing codes repeat bit 0, others show background
    always_comb begin
        col9_out = 1'b0;
        if (mono_in) begin
            col9_out = (char_code_in[7:5] == LINE_GFX_TOP) ? pixels_out[0] : reverse;
        end
    end

endmodule
`default_nettype wire

// [core/tmafl_text_engine.sv]
//
// Contract
// - Attribute bit 7 blinks the cell only while mode control bit 5 is set.
// - Background/foreground fields decode jointly: blank, underline, normal, reverse.
// - 80x25 pages of 4000 bytes sit in 4 Kbyte slots, four per 16 Kbyte.
// - 80x25 rows are 160 bytes apart from the page base.
// - 40x25 pages sit in 2 Kbyte slots; rows are 80 bytes apart.
// - Displayed page base comes from start-address and screen-adjust registers.
// - 60x40 text uses rows 120 bytes apart.
// - The full 8-bit character code picks one of 256 glyphs.
// - Four font areas; exactly one is read, chosen by mode settings.
// - Glyph height comes from the maximum-scan-line register.
// - Each glyph row is fetched as one byte of eight pixels.
// - 8x8 areas span 2 Kbyte; 8x16 and 9x14 areas span 4 Kbyte.
// - The 9x14 font gets its ninth column generated by the device.
// - Character code is read from the even byte, attribute from the next.
// - Font address: code on bits 10..3, row on 2..0, bit 11 for tall fonts.
// - Rows 8 and up of tall fonts lie 2 Kbyte into the area.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module tmafl_text_engine (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  sram_data_in,
    output logic      [7:0]  reg_rdata_out,
    output logic      [14:0] video_sram_address_out,
    output logic      [7:0]  pixel_byte_out,
    output logic             pixel_col9_out,
    output logic      [7:0]  cell_attr_out,
    output logic             high_intensity_out,
    output logic             pixel_valid_out,
    output logic             frame_start_out
);
    import tmafl_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        tmafl_fsm_t  fsm;
        logic [7:0]  mode_ctl;
        logic [1:0]  layout;
        logic [7:0]  start_hi;
        logic [7:0]  start_lo;
        logic [7:0]  adj_hi;
        logic [7:0]  adj_lo;
        logic [4:0]  max_scan;
        logic [7:0]  scr_ctl;
        logic [7:0]  ctl1;
        logic [6:0]  col;
        logic [5:0]  trow;
        logic [3:0]  scan;
        logic [13:0] row_ptr;
        logic [13:0] cell_ptr;
        logic [7:0]  char_code;
        logic [7:0]  attr;
        logic [3:0]  blink_cnt;
        logic        blink_phase;
        logic [14:0] addr;
        logic [7:0]  pix;
        logic        col9;
        logic [7:0]  attr_o;
        logic        hi_int;
        logic        pix_valid;
        logic        frame_start;
        logic [7:0]  rdata;
    } tmafl_state_t;

    tmafl_state_t st;
    tmafl_state_t next_st;

    logic        mono;
    logic        special;
    logic        font2;
    logic        blink_en;
    logic [13:0] page_base;
    logic        last_col;
    logic        last_scan;
    logic        last_row;
    logic [13:0] next_row_ptr;
    logic [7:0]  dec_pixels;
    logic        dec_col9;
    logic        dec_hi;

    // ----------------------------------------------------------------
    // Mode decode and page base
    // ----------------------------------------------------------------
    assign mono      = st.scr_ctl[SCR_MONO_BIT];
    assign special   = st.ctl1[CTL1_SPECIAL_BIT];
    assign font2     = st.scr_ctl[SCR_FONT2_BIT];
    assign blink_en  = st.mode_ctl[MODE_BLINK_BIT];
    // Both register pairs add, so software may use either or both
    assign page_base = 14'({st.start_hi, st.start_lo} + {st.adj_hi, st.adj_lo});
    assign last_col  = st.col == tmafl_last_col(st.layout);
    assign last_scan = st.scan == st.max_scan[3:0];
    assign last_row  = st.trow == tmafl_last_row(st.layout);
    // Rows advance by the layout stride; pages wrap inside the 16 Kbyte area
    assign next_row_ptr = 14'(st.row_ptr + tmafl_stride(st.layout));

    // Attribute and ninth-column decode of the cell being drawn
    tmafl_attr_decode u_attr (
        .attr_in            (st.attr),
        .font_byte_in       (sram_data_in),
        .char_code_in       (st.char_code),
        .mono_in            (mono),
        .blink_en_in        (blink_en),
        .blink_phase_in     (st.blink_phase),
        .underline_row_in   (last_scan),
        .pixels_out         (dec_pixels),
        .col9_out           (dec_col9),
        .high_intensity_out (dec_hi)
    );

    // ----------------------------------------------------------------
    // Next-state logic: register port and fetch sequence
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.pix_valid   = 1'b0;
        next_st.frame_start = 1'b0;
        next_st.rdata       = 8'h00;
        // Register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                REG_MAX_SCAN: next_st.max_scan = reg_wdata_in[4:0];
                REG_START_HI: next_st.start_hi = reg_wdata_in;
                REG_START_LO: next_st.start_lo = reg_wdata_in;
                REG_SCR_CTL:  next_st.scr_ctl  = reg_wdata_in;
                REG_ADJ_HI:   next_st.adj_hi   = reg_wdata_in;
                REG_ADJ_LO:   next_st.adj_lo   = reg_wdata_in;
                REG_CTL1:     next_st.ctl1     = reg_wdata_in;
                REG_MODE_CTL: next_st.mode_ctl = reg_wdata_in;
                REG_LAYOUT:   next_st.layout   = reg_wdata_in[1:0];
                default:      next_st.rdata    = 8'h00;
            endcase
        end
        // Register reads; unmapped offsets read as zero
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_MAX_SCAN: next_st.rdata = {3'h0, st.max_scan};
                REG_START_HI: next_st.rdata = st.start_hi;
                REG_START_LO: next_st.rdata = st.start_lo;
                REG_SCR_CTL:  next_st.rdata = st.scr_ctl;
                REG_ADJ_HI:   next_st.rdata = st.adj_hi;
                REG_ADJ_LO:   next_st.rdata = st.adj_lo;
                REG_CTL1:     next_st.rdata = st.ctl1;
                REG_MODE_CTL: next_st.rdata = st.mode_ctl;
                REG_LAYOUT:   next_st.rdata = {6'h00, st.layout};
                REG_STATUS:   next_st.rdata = {st.blink_phase, 1'b0, st.trow};
                default:      next_st.rdata = 8'h00;
            endcase
        end
        // Three-step cell fetch; SRAM data answers the address in the same cycle
        if (st.mode_ctl[MODE_RUN_BIT]) begin
            case (st.fsm)
                ST_CHAR: begin
                    next_st.char_code = sram_data_in;
                    next_st.addr      = {DISPLAY_TOP, 14'(st.cell_ptr + 14'h0001)};
                    next_st.fsm       = ST_ATTR;
                end
                ST_ATTR: begin
                    next_st.attr = sram_data_in;
                    // One area only, picked by the mode bits
                    next_st.addr = tmafl_font_addr(st.char_code, st.scan, mono, special, font2);
                    next_st.fsm  = ST_FONT;
                end
                ST_FONT: begin
                    next_st.pix       = dec_pixels;
                    next_st.col9      = dec_col9;
                    next_st.hi_int    = dec_hi;
                    next_st.attr_o    = st.attr;
                    next_st.pix_valid = 1'b1;
                    next_st.fsm       = ST_CHAR;
                    if (!last_col) begin
                        next_st.col      = 7'(st.col + 7'h01);
                        next_st.cell_ptr = 14'(st.cell_ptr + CELL_STEP);
                    end else if (!last_scan) begin
                        // Same text row again for the next glyph row
                        next_st.col      = 7'h00;
                        next_st.scan     = 4'(st.scan + 4'h1);
                        next_st.cell_ptr = st.row_ptr;
                    end else if (!last_row) begin
                        next_st.col      = 7'h00;
                        next_st.scan     = 4'h0;
                        next_st.trow     = 6'(st.trow + 6'h01);
                        next_st.row_ptr  = next_row_ptr;
                        next_st.cell_ptr = next_row_ptr;
                    end else begin
                        // Frame end: restart at the page base and step blink
                        next_st.col         = 7'h00;
                        next_st.scan        = 4'h0;
                        next_st.trow        = 6'h00;
                        next_st.row_ptr     = page_base;
                        next_st.cell_ptr    = page_base;
                        next_st.frame_start = 1'b1;
                        next_st.blink_cnt   = 4'(st.blink_cnt + 4'h1);
                        if (st.blink_cnt == BLINK_LAST_FRAME) begin
                            next_st.blink_phase = ~st.blink_phase;
                        end
                    end
                    next_st.addr = {DISPLAY_TOP, next_st.cell_ptr};
                end
                default: next_st.fsm = ST_CHAR;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            st          <= '0;
            st.fsm      <= ST_CHAR;
            st.mode_ctl <= MODE_CTL_RST;
            st.max_scan <= MAX_SCAN_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register
    assign reg_rdata_out          = st.rdata;
    assign video_sram_address_out = st.addr;
    assign pixel_byte_out         = st.pix;
    assign pixel_col9_out         = st.col9;
    assign cell_attr_out          = st.attr_o;
    assign high_intensity_out     = st.hi_int;
    assign pixel_valid_out        = st.pix_valid;
    assign frame_start_out        = st.frame_start;

    // ----------------------------------------------------------------
    // Assertions and covers
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_attr_after_char: assert property (
        st.fsm == ST_ATTR && $past(st.fsm) == ST_CHAR |->
            st.addr[13:0] == 14'($past(st.addr[13:0]) + 14'h0001) && !st.addr[14])
        else $error("attribute fetch not at the byte after the character");

    a_font_code_row: assert property (
        st.fsm == ST_FONT |-> st.addr[10:3] == st.char_code && st.addr[2:0] == st.scan[2:0])
        else $error("font address does not carry code and glyph row");

    // Mode bits of the cycle that built the address; a write may land in between
    a_font_area_one: assert property (
        st.fsm == ST_FONT |->
            st.addr[14:12] == ($past(mono) ? FONT_TOP_MONO : ($past(special) ? FONT_TOP_SPECIAL : FONT_TOP_NARROW)))
        else $error("font fetch outside the selected area");

    a_tall_upper_rows: assert property (
        st.fsm == ST_FONT && ($past(mono) || $past(special)) |-> st.addr[11] == st.scan[3])
        else $error("tall font upper rows not 2 Kbyte into the area");

    a_blink_gate: assert property (
        st.fsm == ST_FONT && mono && !blink_en && st.attr[6:0] == 7'h07 |=>
            pixel_valid_out && pixel_byte_out == $past(sram_data_in))
        else $error("glyph hidden while blinking disabled");

    a_nondisplay_blank: assert property (
        st.fsm == ST_FONT && mono && st.attr[6:4] == FIELD_NONE && st.attr[2:0] == FIELD_NONE |=>
            pixel_byte_out == 8'h00 && !pixel_col9_out)
        else $error("nondisplay cell shows pixels");

    a_reverse_video: assert property (
        st.fsm == ST_FONT && mono && st.attr == 8'h70 |=> pixel_byte_out == ~$past(sram_data_in))
        else $error("reverse video not inverted");

    a_intensity_follow: assert property (
        pixel_valid_out |-> high_intensity_out == cell_attr_out[3])
        else $error("intensity does not follow attribute bit 3");

    a_row_stride: assert property (
        st.fsm == ST_CHAR && $past(st.fsm) == ST_FONT && st.trow != $past(st.trow) && st.trow != 6'h00 |->
            st.row_ptr == 14'($past(st.row_ptr) + tmafl_stride($past(st.layout))) && st.addr[13:0] == st.row_ptr)
        else $error("text row not one stride past the previous");

    a_page_base: assert property (
        frame_start_out |-> st.row_ptr == $past(page_base) && st.cell_ptr == st.row_ptr && st.trow == 6'h00)
        else $error("frame did not restart at the page base");

    a_ninth_colour_off: assert property (
        pixel_valid_out && !$past(mono) |-> !pixel_col9_out)
        else $error("ninth column generated outside monochrome mode");

    c_frame_done:   cover property (frame_start_out);
    c_reverse_cell: cover property (pixel_valid_out && st.attr_o == 8'h70);
    c_tall_fetch:   cover property (st.fsm == ST_FONT && st.addr[11] && special);
    c_blink_hide:   cover property (pixel_valid_out && st.attr_o[7] && blink_en && st.blink_phase);

endmodule
`default_nettype wire

// [testbench/tmafl_sram_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Combinational video SRAM: display cells below 4000h, glyph rows above
module tmafl_sram_model (
    input  wire logic [14:0] addr_in,
    output logic      [7:0]  data_out
);
    // Attribute codes cycle across cells so every decode case but blink hiding is met
    function automatic logic [7:0] gen(input logic [14:0] a);
        logic [7:0] at [8];
        at = '{8'h00, 8'h01, 8'h07, 8'h70, 8'h0f, 8'h87, 8'hf0, 8'h35};
        if (a[14])
            gen = a[7:0] ^ 8'h5a;
        else if (a[0])
            gen = at[a[3:1]]; // Attribute on the odd byte
        else
            gen = a[8:1]; // Character code on the even byte
    endfunction
    // Answers in the same cycle, as the engine samples without a wait
    assign data_out = gen(addr_in);
endmodule
`default_nettype wire

// [testbench/tb_text_mode_attribute_font_layout.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_text_mode_attribute_font_layout;
    import tmafl_pkg::*;
    logic        ref_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [7:0]  sram_data_in, reg_rdata_out, pixel_byte_out, cell_attr_out;
    logic [14:0] video_sram_address_out;
    logic        pixel_col9_out, high_intensity_out, pixel_valid_out, frame_start_out;
    int          n_mismatch = 0, cmp_count = 0, cycles = 0, cells, col, row, frames, ncol, nrow;
    logic [14:0] hist [3];
    logic [13:0] base, stride, ca;
    logic        mono, spec, font2, armed = 1'b0, synced = 1'b0;

    tmafl_text_engine dut (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .sram_data_in, .reg_rdata_out, .video_sram_address_out, .pixel_byte_out, .pixel_col9_out,
        .cell_attr_out, .high_intensity_out, .pixel_valid_out, .frame_start_out);
    tmafl_sram_model sram (.addr_in(video_sram_address_out), .data_out(sram_data_in));

    // -------------------------------------------
    // Clock, checks and bus tasks
    // -------------------------------------------
    always #50 ref_clk_in = ~ref_clk_in;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (exp !== got) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look mid-cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge ref_clk_in);
        chk("register read", exp, reg_rdata_out);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Cell monitor: rebuilds the expected fetch order from page base and stride
    always @(negedge ref_clk_in) begin
        logic [7:0]  code, at, fb, px;
        logic [14:0] fa;
        if (synced && pixel_valid_out) begin
            ca = 14'(base + stride * row + 2 * col);
            chk("cell address", {2'b0, ca}, hist[2]);
            chk("attribute address", hist[2] + 15'h1, hist[1]);
            code = sram.gen(hist[2]);
            at = sram.gen(hist[1]);
            fa = {mono ? 3'h6 : (spec ? 3'h5 : 3'h7), ~(mono | spec) & ~font2, code, 3'h0};
            chk("font address", {1'b0, fa}, hist[0]);
            fb = sram.gen(fa);
            px = fb;
            if (mono && {at[6:4], at[2:0]} == 6'o00)
                px = 8'h00;
            if (mono && {at[6:4], at[2:0]} == 6'o70)
                px = ~fb;
            if (mono && {at[6:4], at[2:0]} == 6'o01)
                px = 8'hff;
            chk("pixels", px, pixel_byte_out);
            chk("attribute", at, cell_attr_out);
            chk("intensity", at[3], high_intensity_out);
            if (mono)
                chk("ninth column", (code[7:5] == 3'h6) ? px[0] : (at[6:0] == 7'h70), pixel_col9_out);
            cells++;
            col++;
            if (col == ncol) begin
                col = 0;
                row++;
            end
        end
        if (armed && frame_start_out) begin
            if (synced) begin
                chk("cells per frame", 16'(ncol * nrow), 16'(cells));
                frames++;
            end
            synced = 1'b1;
            cells = 0;
            col = 0;
            row = 0;
        end
        hist[2] = hist[1];
        hist[1] = hist[0];
        hist[0] = video_sram_address_out;
    end

    // Reprogram, then check one whole frame; one scan per row keeps runs short
    task automatic cfg(input string nm, input logic m, input logic s, input logic f, input logic [1:0] lay,
                       input logic [15:0] st, input logic [15:0] ad, input int c, input int r, input int sd);
        int k;
        armed = 1'b0;
        synced = 1'b0;
        frames = 0;
        mono = m;
        spec = s;
        font2 = f;
        ncol = c;
        nrow = r;
        stride = 14'(sd);
        base = st[13:0] + ad[13:0];
        wr(REG_MAX_SCAN, 8'h00);
        wr(REG_SCR_CTL, {4'h0, f, 2'h0, m});
        wr(REG_CTL1, {5'h0, s, 2'h0});
        wr(REG_LAYOUT, {6'h0, lay});
        wr(REG_START_HI, st[15:8]);
        wr(REG_START_LO, st[7:0]);
        wr(REG_ADJ_HI, ad[15:8]);
        wr(REG_ADJ_LO, ad[7:0]);
        // A frame end on the last write's edge still reloads the old page base
        @(posedge ref_clk_in);
        armed = 1'b1;
        for (k = 0; k < 20000 && frames == 0; k++)
            @(posedge ref_clk_in);
        chk("frames checked", 16'h1, 16'(frames));
        $display("test %s done", nm);
    endtask

    // Cut a hang short well past the expected run length
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 90000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // -------------------------------------------
    // Test sequence
    // -------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd(REG_MAX_SCAN, 8'h07);
        rd(REG_MODE_CTL, 8'h01);
        rd(8'h77, 8'h00);
        wr(REG_START_LO, 8'h5c);
        rd(REG_START_LO, 8'h5c);
        $display("test registers done");
        cfg("mono 80x25 page 1", 1, 0, 0, 2'h0, 16'h1000, 16'h0000, 80, 25, 160);
        cfg("special 60x40 page 2", 0, 1, 0, 2'h2, 16'h1000, 16'h1000, 60, 40, 120);
        cfg("font2 40x25 page 7", 0, 0, 1, 2'h1, 16'h0000, 16'h3800, 40, 25, 80);
        cfg("font1 80x25 wrap", 0, 0, 0, 2'h3, 16'h3c00, 16'h0000, 80, 25, 160);
        complete_run();
    end
endmodule
`default_nettype wire
